/* File: verilog/special_register_write_guard.sv */
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Seven registers are write protected
// - Protected write only directly after command write
// - Broken sequence recorded in system status
// - Store and bit instructions both unlock
// - Protected registers readable without unlock
// - Interrupt acknowledge held after command write
// - Error: unarmed protected or armed other write
// - Reads between leave unlock intact
// - Reset or written zero clears error
// - Command register eight bit write only
module special_register_write_guard (
    input  wire logic                              clk_i,
    input  wire logic                              rstn_i,
    input  wire logic [wguard_pkg::ADDR_W-1:0]     avs_address_i,
    input  wire logic                              avs_read_i,
    input  wire logic                              avs_write_i,
    input  wire logic [wguard_pkg::DATA_W-1:0]     avs_writedata_i,
    input  wire wguard_pkg::bitop_t                avs_bitop_i,
    output logic      [wguard_pkg::DATA_W-1:0]     avs_readdata_o,
    output logic                                   avs_waitrequest_o,
    output wguard_pkg::prot_bank_t                 prot_regs_o,
    output logic      [wguard_pkg::PROT_NUM-1:0]   prot_wr_o,
    output logic                                   int_hold_o,
    output logic                                   irq_o
);
    import wguard_pkg::*;

    // ------------------------------------------------------------
    // Bus slave handshake
    // ------------------------------------------------------------
    logic                ack_q;
    logic                req;
    logic                wr_go;
    logic [DATA_W-1:0]   rdata_q;

    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_q;  // One wait cycle on every access
    assign wr_go             = avs_write_i & ack_q;
    assign avs_readdata_o    = rdata_q;

    // Acknowledge flop, high for one cycle per access
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [PROT_NUM-1:0] prot_hit;
    logic                is_cmd;
    logic                is_sys;
    logic                is_ist;
    logic                is_imk;
    logic                is_prot;

    assign is_cmd  = avs_address_i == CMD_OFS;
    assign is_sys  = avs_address_i == SYS_OFS;
    assign is_ist  = avs_address_i == ISTAT_OFS;
    assign is_imk  = avs_address_i == IMASK_OFS;
    assign is_prot = |prot_hit;

    // State and storage of the guarded bank
    prot_bank_t          prot_q;
    logic [PROT_NUM-1:0] prot_wr_q;
    logic                armed_q;
    logic                err_q;
    evt_t                ist_q;
    evt_t                imk_q;
    logic [PROT_W-1:0]   cur_val;
    logic [PROT_W-1:0]   wval;
    logic                accept;
    logic                err_evt;
    logic                err_clr;

    genvar gi;
    generate
        for (gi = 0; gi < PROT_NUM; gi++) begin : g_slot
            assign prot_hit[gi] = avs_address_i == PROT_BASE_OFS + PROT_STRIDE * ADDR_W'(gi);

            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    prot_q[gi] <= PROT_RST;
                end else if (accept && prot_hit[gi]) begin
                    prot_q[gi] <= wval;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Readback and write data
    // ------------------------------------------------------------
    // Current value of the addressed register
    always_comb begin
        cur_val = 8'h00;
        if (is_cmd) cur_val = CMD_RDATA;
        if (is_sys) cur_val = {7'h00, err_q};
        if (is_ist) cur_val = {6'h00, ist_q};
        if (is_imk) cur_val = {6'h00, imk_q};
        for (int i = 0; i < PROT_NUM; i++) begin
            if (prot_hit[i]) cur_val = prot_q[i];
        end
    end

    bit_modify u_mod (
        .cur_i   (cur_val),
        .wdata_i (avs_writedata_i[7:0]),
        .op_i    (avs_bitop_i),
        .res_o   (wval)
    );

    // Read data captured in the wait cycle, stands at the completing edge
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            rdata_q <= {24'h00_0000, cur_val};
        end
    end

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    // next write consumes unlock
    assign accept  = wr_go & is_prot & armed_q;
    assign err_evt = wr_go & ((is_prot & ~armed_q) | (armed_q & ~is_prot));
    assign err_clr = wr_go & is_sys & ~wval[ERR_BIT];

    // reset disarms; any write rearms or disarms
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed_q <= 1'b0;
        end else if (wr_go) begin
            armed_q <= is_cmd;
        end
    end

    assign int_hold_o = armed_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            err_q <= SYS_RST[ERR_BIT];
        end else if (err_clr) begin
            err_q <= 1'b0;
        end else if (err_evt) begin
            err_q <= 1'b1;
        end
    end

    // Strobe of accepted guarded writes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prot_wr_q <= '0;
        end else begin
            prot_wr_q <= accept ? prot_hit : '0;
        end
    end

    assign prot_regs_o = prot_q;
    assign prot_wr_o   = prot_wr_q;

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    evt_t evt;
    assign evt.prot_done = accept;
    assign evt.prot_err  = err_evt;

    // Sticky events, new event wins over write-one clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ist_q <= EVT_RST;
        end else if (wr_go && is_ist) begin
            ist_q <= (ist_q & ~wval[EVT_W-1:0]) | evt;
        end else begin
            ist_q <= ist_q | evt;
        end
    end

    // Mask register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            imk_q <= EVT_RST;
        end else if (wr_go && is_imk) begin
            imk_q <= wval[EVT_W-1:0];
        end
    end

    assign irq_o = |(ist_q & imk_q);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence cmd_write_s;
        wr_go && is_cmd;
    endsequence

    sequence guarded_write_s;
        wr_go && is_prot;
    endsequence

    chk_bank_only_unlocked: assert property ($changed(prot_q) |-> $past(accept))
        else $error("guarded register changed without unlock");
    chk_unarmed_refused: assert property (guarded_write_s ##0 !armed_q |=> err_q && $stable(prot_q))
        else $error("unarmed guarded write not refused");
    chk_armed_stray_err: assert property (wr_go && armed_q && !is_prot && !err_clr |=> err_q)
        else $error("stray write after unlock not flagged");
    chk_unlock_then_write: assert property (cmd_write_s ##1 (!avs_write_i)[*7] ##2 guarded_write_s
                                             |-> armed_q ##1 (prot_wr_o != '0))
        else $error("read between unlock and write broke sequence");
    chk_read_keeps_unlock: assert property (avs_read_i |=> $stable(armed_q))
        else $error("read changed the unlock state");
    chk_zero_clears: assert property (err_clr |=> !err_q)
        else $error("written zero did not clear error");
    chk_unlock_consumed: assert property (wr_go && !is_cmd |=> !armed_q && !int_hold_o)
        else $error("unlock not consumed by next write");
    chk_hold_after_cmd: assert property (cmd_write_s |=> int_hold_o[*3])
        else $error("interrupt hold dropped before next write");
    chk_accept_strobe: assert property (guarded_write_s ##0 armed_q |=> $onehot(prot_wr_o) ##1 prot_wr_o == '0)
        else $error("accepted guarded write strobe wrong");
    chk_answer_delay: assert property (req && !ack_q |=> !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");
endmodule

/* File: verilog/wguard_pkg.sv */
package wguard_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int PROT_NUM = 7;
    localparam int PROT_W   = 8;
    localparam int EVT_W    = 2;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CMD_OFS       = 8'h00; // protection_command_register, write only
    localparam logic [ADDR_W-1:0] SYS_OFS       = 8'h04; // system_status_register
    localparam logic [ADDR_W-1:0] ISTAT_OFS     = 8'h08; // Interrupt status, write one to clear
    localparam logic [ADDR_W-1:0] IMASK_OFS     = 8'h0c; // Interrupt mask
    localparam logic [ADDR_W-1:0] PROT_BASE_OFS = 8'h10; // First guarded register
    localparam logic [ADDR_W-1:0] PROT_STRIDE   = 8'h04;

    // ------------------------------------------------------------
    // Guarded register slots, offset = base + stride * slot
    // ------------------------------------------------------------
    localparam int SLOT_POWER_SAVE   = 0; // power_save_control_register
    localparam int SLOT_CLOCK_CTRL   = 1; // clock_control_register
    localparam int SLOT_CPU_CLOCK    = 2; // processor_clock_control_register
    localparam int SLOT_CLOCK_MON    = 3; // clock_monitor_mode_register
    localparam int SLOT_RESET_SOURCE = 4; // reset_source_flag_register
    localparam int SLOT_RAM_STATUS   = 5; // internal_ram_status_register
    localparam int SLOT_DEBUG_MODE   = 6; // on_chip_debug_mode_register

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int                ERR_BIT    = 0; // protection_error_flag in system status
    localparam logic [PROT_W-1:0] PROT_RST   = 8'h00;
    localparam logic [PROT_W-1:0] SYS_RST    = 8'h00;
    localparam logic [PROT_W-1:0] CMD_RDATA  = 8'h00; // Command register reads carry no meaning
    localparam logic [EVT_W-1:0]  EVT_RST    = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BITOP_NONE = 2'b00,
        BITOP_SET  = 2'b01,
        BITOP_CLR  = 2'b10,
        BITOP_INV  = 2'b11
    } bitop_t;

    typedef logic [PROT_NUM-1:0][PROT_W-1:0] prot_bank_t;

    typedef struct packed {
        logic prot_done;
        logic prot_err;
    } evt_t;

endpackage

/* File: verilog/bit_modify.sv */
`timescale 1ns/1ns
module bit_modify (
    input  wire logic [7:0]            cur_i,
    input  wire logic [7:0]            wdata_i,
    input  wire wguard_pkg::bitop_t    op_i,
    output logic      [7:0]            res_o
);
    import wguard_pkg::*;

    logic [7:0] sel;

    // One-hot mask of the addressed bit
    assign sel = 8'h01 << wdata_i[2:0];

    // Plain store or single-bit set, clear, invert
    always_comb begin
        case (op_i)
            BITOP_SET: res_o = cur_i | sel;
            BITOP_CLR: res_o = cur_i & ~sel;
            BITOP_INV: res_o = cur_i ^ sel;
            default:   res_o = wdata_i;
        endcase
    end
endmodule

/* File: verification/cpu_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// CPU core issuing loads and stores
// ----------------------------------------
module cpu_model (
    input  wire logic                          clk_i,
    input  wire logic                          waitrequest_i,
    input  wire logic [wguard_pkg::DATA_W-1:0] readdata_i,
    output logic      [wguard_pkg::ADDR_W-1:0] address_o,
    output logic                               read_o,
    output logic                               write_o,
    output logic      [wguard_pkg::DATA_W-1:0] writedata_o,
    output wguard_pkg::bitop_t                 bitop_o,
    output logic                               hang_o
);
    import wguard_pkg::*;

    // Idle bus at time zero
    initial begin
        address_o   = '0;
        read_o      = 1'b0;
        write_o     = 1'b0;
        writedata_o = '0;
        bitop_o     = BITOP_NONE;
        hang_o      = 1'b0;
    end

    // one access at a time, nothing interleaved
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          input bitop_t op, output logic [DATA_W-1:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        address_o   <= a;
        writedata_o <= d;
        bitop_o     <= op;
        write_o     <= wr;
        read_o      <= !wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 20);
        q = readdata_i;
        hang_o      <= (waitrequest_i !== 1'b0);
        read_o      <= 1'b0;
        write_o     <= 1'b0;
        address_o   <= ~a; // Released lines drop the stale value
        writedata_o <= ~d;
    endtask

    task automatic nops(input int k);
        repeat (k) @(posedge clk_i);
    endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module testbench;
    import wguard_pkg::*;

    // ----------------------------------------
    // Clock, reset and wiring
    // ----------------------------------------
    logic        clk_i  = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  addr;
    logic        rd_s;
    logic        wr_s;
    logic [31:0] wdata;
    bitop_t      op_s;
    logic [31:0] rdata;
    logic        wait_s;
    prot_bank_t  bank;
    logic [6:0]  pulse;
    logic        int_hold_o;
    logic        irq_o;
    logic        hang;
    int          errors  = 0;
    int          checked = 0;
    logic [7:0]  e;

    always #5 clk_i = ~clk_i;

    special_register_write_guard uut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(addr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_bitop_i(op_s),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s), .prot_regs_o(bank), .prot_wr_o(pulse),
        .int_hold_o(int_hold_o), .irq_o(irq_o));

    cpu_model cpu (.clk_i(clk_i), .waitrequest_i(wait_s), .readdata_i(rdata), .address_o(addr),
        .read_o(rd_s), .write_o(wr_s), .writedata_o(wdata), .bitop_o(op_s), .hang_o(hang));

    // ----------------------------------------
    // Access tasks and verdict
    // ----------------------------------------
    function automatic logic [7:0] sa(input int s);
        return PROT_BASE_OFS + 8'(PROT_STRIDE * s);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input bitop_t op = BITOP_NONE);
        logic [31:0] q;
        cpu.access(1'b1, a, d, op, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        cpu.access(1'b0, a, '0, BITOP_NONE, q);
        `CHK(q, exp, msg)
    endtask

    task automatic finish_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Bus hang ends the run
    always @(posedge hang) begin
        errors++;
        $display("mismatch at %0t: bus wait ran out", $time);
        finish_test();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1 `CHK(bank, '0, "bank after reset")
        `CHK(int_hold_o, 1'b0, "hold after reset")
        rd(SYS_OFS, 32'h0, "status after reset");
        $display("test reset done");
        for (int s = 0; s < PROT_NUM; s++) begin
            wr(CMD_OFS, 32'(8'h11 * (s + 1)));
            #1 `CHK(int_hold_o, 1'b1, "hold while armed")
            wr(sa(s), 32'(8'h11 * (s + 1)));
            #1 `CHK(pulse, 7'(1 << s), "write pulse")
            `CHK(bank[s], 8'(8'h11 * (s + 1)), "slot value")
            `CHK(int_hold_o, 1'b0, "hold after write")
            if (s == SLOT_POWER_SAVE) begin
                cpu.nops(5);
            end
        end
        rd(SYS_OFS, 32'h0, "no error after legal writes");
        rd(sa(3), 32'h44, "plain read of slot");
        $display("test unlock done");
        wr(sa(0), 32'h5a);
        #1 `CHK(bank[0], 8'h11, "refused write")
        `CHK(pulse, 7'h00, "no pulse")
        rd(SYS_OFS, 32'h1, "error on unarmed write");
        rd(ISTAT_OFS, 32'h3, "event status");
        `CHK(irq_o, 1'b0, "irq masked")
        wr(IMASK_OFS, 32'h1);
        rd(IMASK_OFS, 32'h1, "mask readback");
        `CHK(irq_o, 1'b1, "irq raised")
        wr(ISTAT_OFS, 32'h3);
        rd(ISTAT_OFS, 32'h0, "events cleared");
        `CHK(irq_o, 1'b0, "irq cleared")
        wr(SYS_OFS, 32'h0);
        rd(SYS_OFS, 32'h0, "error cleared");
        $display("test refusal done");
        wr(CMD_OFS, 32'h2c);
        rd(sa(2), 32'h33, "read between");
        rd(CMD_OFS, 32'(CMD_RDATA), "command read");
        wr(sa(2), 32'h2c);
        #1 `CHK(bank[2], 8'h2c, "write after read")
        rd(SYS_OFS, 32'h0, "read sets no error");
        e = 8'h22;
        for (int k = 1; k < 4; k++) begin
            e = (k == 1) ? (e | 8'h08) : (k == 2) ? (e & 8'hf7) : (e ^ 8'h08);
            wr(CMD_OFS, 32'h3);
            wr(sa(1), 32'h3, bitop_t'(k));
            #1 `CHK(bank[1], e, "bit op result")
        end
        $display("test bit ops done");
        wr(CMD_OFS, 32'h0);
        wr(8'h80, 32'h0);
        rd(SYS_OFS, 32'h1, "armed other write");
        wr(sa(4), 32'h99);
        #1 `CHK(bank[4], 8'h55, "unlock consumed")
        wr(CMD_OFS, 32'h0);
        wr(SYS_OFS, 32'h0);
        rd(SYS_OFS, 32'h0, "zero wins after command");
        rd(8'h80, 32'h0, "unmapped read");
        $display("test misuse done");
        wr(CMD_OFS, 32'h7);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1 `CHK(int_hold_o, 1'b0, "reset disarms")
        wr(sa(6), 32'h7);
        #1 `CHK(bank[6], 8'h00, "no write after reset")
        rd(SYS_OFS, 32'h1, "error after reset");
        $display("test reset mid-run done");
        finish_test();
    end
endmodule
